// ==== tsc_timer_status_control.sv ====
// Global status and control of a multi-channel timer/PWM module.
// Assumes an APB master on clk and a fixed-frequency clock enable pin.

// Behaviour
// - Set overflow flag when counter wraps to zero after reaching modulo.
// - Flag clears only on read while set, then write of zero.
// - An overflow between read and write restarts the clearing sequence.
// - Writing one leaves flag alone; reset clears it.
// - Enable bit plus flag raises interrupt request when mask bit 0 is set; reset clears enable.
// - Select clear: counter counts up, channels follow own mode bits.
// - Select set: up/down counting, all channels centre-aligned PWM.
// - Reset clears centre-align select, giving up-counting mode.
// - Clock source: 00 none, 01 bus, 10 fixed clock, 11 unavailable.
// - Prescale divides selected clock by two to the field value.
// - Prescaler divides whichever clock has been selected.
// - New prescale value acts on the next bus clock cycle.
// - Any control register write restarts the counter read latch.
// - Any control register write resets modulo byte-pair write latch.
module tsc_timer_status_control (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Timer core
	input wire logic counter_wrap,
	input wire logic fixed_clk_tick,
	output logic count_tick,
	output logic count_enable,
	output logic count_updown,
	output logic center_aligned_pwm,
	output logic restart_read_latch,
	output logic reset_mod_latch,
	// Interrupt
	output logic irq
);

	logic overflow_flag_q;
	logic overflow_irq_enable_q;
	logic center_align_select_q;
	logic [1:0] clock_source_select_q;
	logic [tsc_pkg::PS_W-1:0] prescale_select_q;
	logic clear_armed_q;
	logic [1:0] irq_status_q;
	logic [1:0] irq_mask_q;
	logic fixed_tick_s;
	logic fixed_tick_d1_q;
	logic src_tick;
	logic presc_tick;
	logic access;
	logic wr;
	logic rd;
	logic [7:0] sc_value;

	function automatic logic hit(input logic [11:0] a, input logic [11:0] r);
		hit = (a == r);
	endfunction : hit

	assign access = psel && penable;
	assign wr = access && pwrite;
	assign rd = access && !pwrite;
	assign sc_value = {overflow_flag_q, overflow_irq_enable_q,
		center_align_select_q, clock_source_select_q, prescale_select_q};

	// The fixed clock arrives from another domain; only its rising edge
	// after the synchroniser counts as one source tick.
	tsc_sync u_fixed_sync (
		.clk(clk),
		.rst(rst),
		.d(fixed_clk_tick),
		.q(fixed_tick_s)
	);

	always_ff @(posedge clk) begin
		if (rst) begin
			fixed_tick_d1_q <= 1'b0;
		end else begin
			fixed_tick_d1_q <= fixed_tick_s;
		end
	end

	// Unavailable code gives no clock, so a stray code cannot run the
	// counter from an undefined source.
	always_comb begin
		unique case (clock_source_select_q)
			tsc_pkg::CLK_BUS: src_tick = 1'b1;
			tsc_pkg::CLK_FIXED: src_tick = fixed_tick_s && !fixed_tick_d1_q;
			tsc_pkg::CLK_UNAVAIL: src_tick = 1'b0;
			default: src_tick = 1'b0;
		endcase
	end

	tsc_prescaler #(
		.DIV_W(tsc_pkg::DIV_W)
	) u_prescaler (
		.clk(clk),
		.rst(rst),
		.prescale_select(prescale_select_q),
		.src_tick(src_tick),
		.tick(presc_tick)
	);

	// Control fields of the status/control register.
	always_ff @(posedge clk) begin
		if (rst) begin
			overflow_irq_enable_q <= tsc_pkg::SC_RESET[tsc_pkg::OIE_BIT];
			center_align_select_q <= tsc_pkg::SC_RESET[tsc_pkg::CAS_BIT];
			clock_source_select_q <=
				tsc_pkg::SC_RESET[tsc_pkg::CLK_HI:tsc_pkg::CLK_LO];
			prescale_select_q <= tsc_pkg::SC_RESET[tsc_pkg::PS_HI:tsc_pkg::PS_LO];
		end else if (wr && hit(paddr, tsc_pkg::ADDR_STATUS_CONTROL)) begin
			overflow_irq_enable_q <= pwdata[tsc_pkg::OIE_BIT];
			center_align_select_q <= pwdata[tsc_pkg::CAS_BIT];
			clock_source_select_q <= pwdata[tsc_pkg::CLK_HI:tsc_pkg::CLK_LO];
			prescale_select_q <= pwdata[tsc_pkg::PS_HI:tsc_pkg::PS_LO];
		end
	end

	// Overflow flag with its read-then-write-zero clearing sequence.
	// A wrap always wins and disarms, so a fresh overflow needs a new read.
	always_ff @(posedge clk) begin
		if (rst) begin
			overflow_flag_q <= 1'b0;
			clear_armed_q <= 1'b0;
		end else if (counter_wrap) begin
			overflow_flag_q <= 1'b1;
			clear_armed_q <= 1'b0;
		end else if (rd && hit(paddr, tsc_pkg::ADDR_STATUS_CONTROL) &&
			overflow_flag_q) begin
			clear_armed_q <= 1'b1;
		end else if (wr && hit(paddr, tsc_pkg::ADDR_STATUS_CONTROL)) begin
			if (clear_armed_q && !pwdata[tsc_pkg::OVF_BIT]) begin
				overflow_flag_q <= 1'b0;
			end
			clear_armed_q <= 1'b0;
		end
	end

	// Sticky event status, write one to clear; a new event wins.
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_status_q <= tsc_pkg::IRQ_RESET;
		end else begin
			irq_status_q[tsc_pkg::EV_OVF] <= (overflow_flag_q &&
				overflow_irq_enable_q) || (irq_status_q[tsc_pkg::EV_OVF] &&
				!(wr && hit(paddr, tsc_pkg::ADDR_IRQ_STATUS) &&
				pwdata[tsc_pkg::EV_OVF]));
			irq_status_q[tsc_pkg::EV_WRAP] <= counter_wrap ||
				(irq_status_q[tsc_pkg::EV_WRAP] &&
				!(wr && hit(paddr, tsc_pkg::ADDR_IRQ_STATUS) &&
				pwdata[tsc_pkg::EV_WRAP]));
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			irq_mask_q <= tsc_pkg::IRQ_RESET;
		end else if (wr && hit(paddr, tsc_pkg::ADDR_IRQ_MASK)) begin
			irq_mask_q <= pwdata[1:0];
		end
	end

	// The overflow source is re-evaluated from the flag, so the request
	// stays up for as long as the flag, enable and mask bit EV_OVF are all set.
	always_ff @(posedge clk) begin
		if (rst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_status_q & irq_mask_q) ||
				(overflow_flag_q && overflow_irq_enable_q &&
				irq_mask_q[tsc_pkg::EV_OVF]);
		end
	end

	// Outputs to the timer core.
	always_ff @(posedge clk) begin
		if (rst) begin
			count_tick <= 1'b0;
			count_enable <= 1'b0;
			count_updown <= 1'b0;
			center_aligned_pwm <= 1'b0;
		end else begin
			count_tick <= presc_tick;
			count_enable <= (clock_source_select_q == tsc_pkg::CLK_BUS) ||
				(clock_source_select_q == tsc_pkg::CLK_FIXED);
			count_updown <= center_align_select_q;
			center_aligned_pwm <= center_align_select_q;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			restart_read_latch <= 1'b0;
			reset_mod_latch <= 1'b0;
		end else begin
			restart_read_latch <= wr &&
				hit(paddr, tsc_pkg::ADDR_STATUS_CONTROL);
			reset_mod_latch <= wr &&
				hit(paddr, tsc_pkg::ADDR_STATUS_CONTROL);
		end
	end

	// APB slave: no wait states, read data registered.
	always_ff @(posedge clk) begin
		if (rst) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= psel && !penable;
			pslverr <= psel && !penable &&
				!(hit(paddr, tsc_pkg::ADDR_STATUS_CONTROL) ||
				hit(paddr, tsc_pkg::ADDR_IRQ_STATUS) ||
				hit(paddr, tsc_pkg::ADDR_IRQ_MASK) ||
				hit(paddr, tsc_pkg::ADDR_EVENT));
			prdata <= 32'h0000_0000;
			if (psel && !penable && !pwrite) begin
				if (hit(paddr, tsc_pkg::ADDR_STATUS_CONTROL)) begin
					prdata <= {24'h00_0000, sc_value};
				end else if (hit(paddr, tsc_pkg::ADDR_IRQ_STATUS)) begin
					prdata <= {30'h0000_0000, irq_status_q};
				end else if (hit(paddr, tsc_pkg::ADDR_IRQ_MASK)) begin
					prdata <= {30'h0000_0000, irq_mask_q};
				end else if (hit(paddr, tsc_pkg::ADDR_EVENT)) begin
					prdata <= {29'h0000_0000, presc_tick, src_tick,
						clear_armed_q};
				end
			end
		end
	end

endmodule : tsc_timer_status_control

// ==== tsc_pkg.sv ====
// Package for the timer status and control block: register map and fields.
// Assumes a 32-bit APB slave, one aligned word for each register.
package tsc_pkg;

	// Register byte addresses.
	localparam logic [11:0] ADDR_STATUS_CONTROL = 12'h000;
	localparam logic [11:0] ADDR_IRQ_STATUS = 12'h004;
	localparam logic [11:0] ADDR_IRQ_MASK = 12'h008;
	localparam logic [11:0] ADDR_EVENT = 12'h00c;

	// Field positions of the status/control register.
	localparam int OVF_BIT = 7;
	localparam int OIE_BIT = 6;
	localparam int CAS_BIT = 5;
	localparam int CLK_HI = 4;
	localparam int CLK_LO = 3;
	localparam int PS_HI = 2;
	localparam int PS_LO = 0;

	// Reset values.
	localparam logic [7:0] SC_RESET = 8'h00;
	localparam logic [1:0] IRQ_RESET = 2'h0;

	// Interrupt status bits.
	localparam int EV_OVF = 0;
	localparam int EV_WRAP = 1;

	// Clock source codes.
	localparam logic [1:0] CLK_NONE = 2'h0;
	localparam logic [1:0] CLK_BUS = 2'h1;
	localparam logic [1:0] CLK_FIXED = 2'h2;
	localparam logic [1:0] CLK_UNAVAIL = 2'h3;

	// Widths.
	localparam int PS_W = 3;
	localparam int DIV_W = 7;

endpackage : tsc_pkg

// ==== tsc_sync.sv ====
// Two-flop synchroniser for a level coming from outside the bus clock.
// Assumes the first flop is read only by the second.
module tsc_sync (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Data
	input wire logic d,
	output logic q
);

	logic meta_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q <= 1'b0;
			q <= 1'b0;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule : tsc_sync

// ==== tsc_prescaler.sv ====
// Power-of-two prescaler on the selected timer clock enable.
// Assumes src_tick is a one-cycle pulse on the bus clock.
module tsc_prescaler #(
	parameter int DIV_W = tsc_pkg::DIV_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Control
	input wire logic [tsc_pkg::PS_W-1:0] prescale_select,
	input wire logic src_tick,
	// Result
	output logic tick
);

	logic [DIV_W-1:0] div_q;
	logic [DIV_W:0] mask;

	// The mask is taken straight from the register, so a new factor acts
	// on the very next bus clock cycle.
	assign mask = ({{DIV_W{1'b0}}, 1'b1} << prescale_select) - 1'b1;

	always_ff @(posedge clk) begin
		if (rst) begin
			div_q <= '0;
		end else if (src_tick) begin
			div_q <= div_q + 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			tick <= 1'b0;
		end else begin
			tick <= src_tick && ((div_q & mask[DIV_W-1:0]) ==
				mask[DIV_W-1:0]);
		end
	end

endmodule : tsc_prescaler

// ==== tsc_sva.sv ====
// Port checker for the timer status/control block.
// Assumes a bind to tsc_timer_status_control on its bus clock.
module tsc_sva (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// APB
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	// Timer core
	input wire logic counter_wrap,
	input wire logic count_tick,
	input wire logic count_enable,
	input wire logic count_updown,
	input wire logic center_aligned_pwm,
	input wire logic restart_read_latch,
	input wire logic reset_mod_latch,
	input wire logic irq
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	logic sc_wr;
	assign sc_wr = psel && penable && pready && pwrite && paddr == 12'h000;
	a_flag_on_wrap: assert property (
		counter_wrap ##1 (psel && !penable && !pwrite && paddr == 12'h000)
		##1 pready |-> prdata[7]) else $error("flag missing after wrap");
	a_rd_latch_go: assert property (
		sc_wr |=> restart_read_latch) else $error("no read latch restart");
	a_rd_latch_why: assert property (
		restart_read_latch |-> $past(sc_wr)) else $error("stray latch restart");
	a_mod_latch_go: assert property (
		1'b1 |=> reset_mod_latch == $past(sc_wr)) else $error("mod latch pulse");
	a_mode_pair: assert property (
		count_updown == center_aligned_pwm) else $error("mode outputs differ");
	a_reset_quiet: assert property (
		@(posedge clk) disable iff (1'b0) $fell(rst) |->
		!count_updown && !center_aligned_pwm && !irq) else $error("reset state");
	a_tick_gated: assert property (
		(!count_enable) [*6] |-> !count_tick) else $error("tick while off");
	a_ready_first: assert property (
		(psel && !penable) |=> pready) else $error("late ready");
endmodule : tsc_sva

// ==== tsc_tb.sv ====
// Self-checking bench for the timer status/control block.
// Assumes the design files and the checker are compiled first.
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic counter_wrap = 0, fixed_clk_tick = 0, er;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, count_tick, count_enable, count_updown;
	logic center_aligned_pwm, irq;
	logic [17:0] rows [0:4];
	int n_fail = 0, cmp_count = 0, c;
	tsc_timer_status_control dut (.clk(clk), .rst(rst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.counter_wrap(counter_wrap), .fixed_clk_tick(fixed_clk_tick),
		.count_tick(count_tick), .count_enable(count_enable),
		.count_updown(count_updown), .center_aligned_pwm(center_aligned_pwm),
		.restart_read_latch(), .reset_mod_latch(), .irq(irq));
	initial begin
		forever #20 clk = ~clk;
	end
	task stop_test;
		$display("compares %0d mismatches %0d", cmp_count, n_fail);
		if (n_fail == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : stop_test
	task check(input string s, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", s, exp, seen);
		end
	endtask : check
	// The wrap pulse is dropped here so a read can follow it at once.
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		counter_wrap <= 0;
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1) break;
		end
		if (i == 20) begin
			n_fail++;
			stop_test();
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task wrap;
		@(posedge clk);
		counter_wrap <= 1;
	endtask : wrap
	task wait_irq(input logic e);
		int i;
		for (i = 0; i < 10 && irq !== e; i++) @(posedge clk);
		if (i == 10) begin
			n_fail++;
			stop_test();
		end
	endtask : wait_irq
	task ticks(input int n, input logic fx);
		c = 0;
		for (int i = 0; i < n; i++) begin
			@(posedge clk);
			if (fx && i % 4 == 0) fixed_clk_tick <= ~fixed_clk_tick;
			if (count_tick === 1'b1) c++;
		end
	endtask : ticks
	initial begin
		rows = '{{8'h08, 8'h08, 2'b10}, {8'h30, 8'h30, 2'b11},
			{8'h18, 8'h18, 2'b00}, {8'h47, 8'h47, 2'b00}, {8'h80, 8'h00, 2'b00}};
		repeat (4) @(posedge clk);
		rst <= 0;
		apb(0, 12'h000, 0);
		check("sc reset", rd, 0);
		apb(0, 12'h008, 0);
		check("mask reset", rd, 0);
		apb(0, 12'h010, 0);
		check("unmapped err", er, 1);
		check("unmapped data", rd, 0);
		foreach (rows[k]) begin
			apb(1, 12'h000, 32'(rows[k][17:10]));
			apb(0, 12'h000, 0);
			check("sc", rd, 32'(rows[k][9:2]));
			check("enable", count_enable, rows[k][1]);
			check("updown", count_updown, rows[k][0]);
			check("center_aligned_pwm", center_aligned_pwm, rows[k][0]);
		end
		for (int p = 0; p < 8; p++) begin
			apb(1, 12'h000, 32'h8 | 32'(p));
			ticks(128, 0);
			ticks(256, 0);
			check("bus div", c, 256 >> p);
		end
		apb(1, 12'h000, 32'h10);
		ticks(64, 1);
		ticks(128, 1);
		check("fixed div", c >= 15 && c <= 17, 1);
		apb(1, 12'h000, 32'h18);
		ticks(32, 1);
		ticks(64, 1);
		check("code 11", c, 0);
		apb(1, 12'h008, 1);
		apb(1, 12'h000, 32'h40);
		wrap();
		apb(0, 12'h000, 0);
		check("flag set", rd[7], 1);
		wait_irq(1);
		// Read arms the clear, then a new wrap must restart the sequence.
		apb(0, 12'h000, 0);
		wrap();
		apb(1, 12'h000, 32'h40);
		apb(0, 12'h000, 0);
		check("restart", rd[7], 1);
		apb(1, 12'h000, 32'h40);
		apb(0, 12'h000, 0);
		check("cleared", rd[7], 0);
		apb(1, 12'h004, 3);
		wait_irq(0);
		apb(1, 12'h000, 0);
		wrap();
		apb(0, 12'h004, 0);
		check("status", rd, 2);
		check("no irq", irq, 0);
		apb(1, 12'h008, 3);
		wait_irq(1);
		apb(1, 12'h004, 2);
		wait_irq(0);
		apb(1, 12'h000, 32'h77);
		rst <= 1;
		repeat (4) @(posedge clk);
		rst <= 0;
		apb(0, 12'h000, 0);
		check("sc rerst", rd, 0);
		check("irq rerst", irq, 0);
		stop_test();
	end
endmodule : tb
bind tsc_timer_status_control tsc_sva chk (.clk(clk), .rst(rst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.prdata(prdata), .pready(pready), .counter_wrap(counter_wrap),
	.count_tick(count_tick), .count_enable(count_enable),
	.count_updown(count_updown), .center_aligned_pwm(center_aligned_pwm),
	.restart_read_latch(restart_read_latch),
	.reset_mod_latch(reset_mod_latch), .irq(irq));
